// ---- dv/dwg_host.sv ----
// serial host model that drives the link of the decoder
`default_nettype none
module dwg_host (
  // link pins towards the device
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din,
  // read-back pin from the device
  input wire logic i_dout
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle link: deselected, clock parked high
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end

  // one frame of the top n bits of v, msb first; rx holds dout seen after each fall
  task automatic frame(input logic [23:0] v, input int n, output logic [23:0] rx);
    rx = '0;
    // step off the system clock edge so no pin moves as the synchroniser samples
    #1;
    o_cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      o_din = v[23-i];
      #62.5;
      rx = {rx[22:0], i_dout};
      o_sclk = 1'b0;
      #62.5;
      o_sclk = 1'b1;
    end
    #62.5;
    rx = {rx[22:0], i_dout};
    o_cs_n = 1'b1;
    o_din = ~o_din; // released line must not keep its last value
    #200;
  endtask
endmodule
`default_nettype wire

// ---- dv/dwg_top_bench.sv ----
// self-checking testbench for the dac word and gpio read decoder
`default_nettype none
module dac_word_and_gpio_read_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dwg_pkg::*;

  logic clk;
  logic nrst;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic [3:0] gpio;
  logic [23:0] rx;
  dwg_code_t dac[4];
  dwg_code_t inr[4];
  dwg_code_t dac_m[4] = '{default: '0};
  dwg_code_t in_m[4] = '{default: '0};
  logic [3:0] nop[6] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB};
  int mismatches = 0;
  int n_compared = 0;

  // device under test and the host on its link
  dwg_top uut (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_CS_N(cs_n), .I_SCLK(sclk), .I_DIN(din), .O_DOUT(dout),
    .I_GPIO_C1_A(gpio[3]), .I_GPIO_C0_B(gpio[2]), .I_GPIO_A1_C(gpio[1]), .I_GPIO_A0_D(gpio[0]),
    .O_DAC0_CODE(dac[0]), .O_DAC1_CODE(dac[1]), .O_DAC2_CODE(dac[2]), .O_DAC3_CODE(dac[3]),
    .O_IN0_CODE(inr[0]), .O_IN1_CODE(inr[1]), .O_IN2_CODE(inr[2]), .O_IN3_CODE(inr[3])
  );
  dwg_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout));

  // system clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // compare every code register against the model
  task automatic check_all();
    for (int i = 0; i < 4; i++) begin
      check({6'h0, inr[i]}, {6'h0, in_m[i]});
      check({6'h0, dac[i]}, {6'h0, dac_m[i]});
    end
  endtask

  // send one dac word behind a select command and update the model
  task automatic do_word(input logic [3:0] ctrl, input dwg_code_t d);
    for (int i = 0; i < 4; i++) begin
      if (ctrl == 4'h1) begin
        in_m[i] = {10{d[9]}};
        dac_m[i] = {10{d[9]}};
      end
      if (ctrl == 4'hA || ctrl == 4'hC) dac_m[i] = d;
      if (ctrl == 4'hA || ctrl == 4'hC || ctrl == 4'hD || ctrl == 4'h2 + 4'(i)) in_m[i] = d;
      if (ctrl == 4'hE && d[2+i]) dac_m[i] = in_m[i];
    end
    @(posedge clk);
    host.frame({4'h1, ctrl, ctrl, d, 2'b10}, 24, rx);
    check_all();
    $display("word test %h done", ctrl);
  endtask

  // gpio read: pins are set first, din is all ones during the data byte
  task automatic gpio_read(input logic [3:0] pins);
    @(posedge clk);
    gpio <= pins;
    host.frame({8'h01, 8'hFF, 8'h00}, 16, rx);
    check({8'h0, rx[8:1]}, {12'h0, pins});
    $display("gpio read test %h done", pins);
  endtask

  // closing report
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of about 72 us
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    gpio = 4'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    check_all();
    $display("reset test done");
    for (int c = 2; c < 6; c++) do_word(4'(c), 10'h0C1 + 10'(c));
    do_word(4'hD, 10'h3A5);
    do_word(4'hE, 10'h014);
    do_word(4'h3, 10'h155);
    do_word(4'hE, 10'h03C);
    foreach (nop[k]) do_word(nop[k], 10'h3FF);
    do_word(4'hA, 10'h2C3);
    do_word(4'hC, 10'h13C);
    @(posedge clk);
    host.frame({8'h10, 4'hA, 10'h2AA, 2'b00}, 18, rx);
    check_all();
    $display("aborted word test done");
    @(posedge clk);
    host.frame({8'h20, 4'hA, 10'h155, 2'b00}, 24, rx);
    check_all();
    $display("foreign command test done");
    do_word(4'h1, 10'h200);
    do_word(4'h1, 10'h1FF);
    gpio_read(4'hA);
    gpio_read(4'h5);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- hdl/dwg_defines.svh ----
// constants for the dac word and gpio read decoder
`ifndef DWG_DEFINES_SVH
`define DWG_DEFINES_SVH

// serial framing
`define DWG_CMD_LAST 4'h7
`define DWG_WORD_LAST 4'hF
`define DWG_GPIO_LAST 4'h7
`define DWG_CNT_ZERO 4'h0
`define DWG_CNT_ONE 4'h1
`define DWG_DAC_SEL_NIB 4'h1
`define DWG_GPIO_READ 8'h01
`define DWG_NIB_HI 7:4

// word fields
`define DWG_CTRL_FLD 15:12
`define DWG_DATA_FLD 11:2
`define DWG_TOP_DATA 11
`define DWG_SEL_FLD 7:4

// control codes
`define DWG_OP_CLRSET 4'h1
`define DWG_OP_LOAD0 4'h2
`define DWG_OP_LOAD3 4'h5
`define DWG_OP_WT_A 4'hA
`define DWG_OP_WT_B 4'hC
`define DWG_OP_IN_ALL 4'hD
`define DWG_OP_XFER 4'hE
`define DWG_OP_PWR 4'hF
`define DWG_OP_NOP_B 4'hB

// register values
`define DWG_CODE_ZERO 10'h000
`define DWG_CODE_FULL 10'h3FF
`define DWG_BYTE_ZERO 8'h00
`define DWG_WORD_ZERO 16'h0000
`define DWG_NIB_ZERO 4'h0

// synchroniser bundle: {cs_n, sclk, din, gpio[3:0]}
`define DWG_SYNC_W 7
`define DWG_SYNC_RST 7'h40

`endif

// ---- hdl/dwg_pkg.sv ----
// types for the dac word and gpio read decoder
`default_nettype none
package dwg_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DAC, ST_GPIO, ST_SKIP} dwg_state_t;
  typedef logic [9:0] dwg_code_t;
endpackage
`default_nettype wire

// ---- hdl/dwg_sync.sv ----
// three-flop pin synchroniser with second/third agreement filter
`default_nettype none
module dwg_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // pins and filtered result
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // a bit moves on only when the second and third stages agree
  assign agree = ~(s2_q ^ s3_q);

  // synchroniser chain; the first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      o_sync <= RST;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_sync <= (s2_q & agree) | (o_sync & ~agree);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/dwg_top.sv ----
// serial dac word decoder with gpio read-back
`include "dwg_defines.svh"
`default_nettype none
module dwg_top (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  // serial link pins
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_DIN,
  output logic O_DOUT,
  // gpio pin states
  input wire logic I_GPIO_C1_A,
  input wire logic I_GPIO_C0_B,
  input wire logic I_GPIO_A1_C,
  input wire logic I_GPIO_A0_D,
  // dac register contents
  output dwg_pkg::dwg_code_t O_DAC0_CODE,
  output dwg_pkg::dwg_code_t O_DAC1_CODE,
  output dwg_pkg::dwg_code_t O_DAC2_CODE,
  output dwg_pkg::dwg_code_t O_DAC3_CODE,
  // input register contents
  output dwg_pkg::dwg_code_t O_IN0_CODE,
  output dwg_pkg::dwg_code_t O_IN1_CODE,
  output dwg_pkg::dwg_code_t O_IN2_CODE,
  output dwg_pkg::dwg_code_t O_IN3_CODE
);
  import dwg_pkg::*;

  // channel index decoded from a single-channel load code
  function automatic logic [1:0] load_chan(input logic [3:0] ctrl);
    logic [3:0] diff;
    diff = ctrl - `DWG_OP_LOAD0;
    return diff[1:0];
  endfunction

  logic [`DWG_SYNC_W-1:0] sync_out;
  logic s_cs_n;
  logic s_sclk;
  logic s_din;
  logic [3:0] s_gpio;
  logic sclk_prev_q;
  dwg_state_t state_q;
  dwg_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [15:0] shift_q;
  logic [7:0] dout_sh_q;
  logic [7:0] dout_sh_d;
  dwg_code_t in_q [4];
  dwg_code_t dac_q [4];

  // pins pass the three-flop synchroniser
  dwg_sync #(
    .W(`DWG_SYNC_W),
    .RST(`DWG_SYNC_RST)
  ) u_sync (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_async({I_CS_N, I_SCLK, I_DIN, I_GPIO_C1_A, I_GPIO_C0_B, I_GPIO_A1_C, I_GPIO_A0_D}),
    .o_sync(sync_out)
  );
  assign s_cs_n = sync_out[6];
  assign s_sclk = sync_out[5];
  assign s_din = sync_out[4];
  assign s_gpio = sync_out[3:0];

  // framing decode
  logic fall;
  logic [15:0] shift_w;
  logic cmd_done;
  logic [7:0] cmd_byte;
  logic to_dac;
  logic to_gpio;
  logic word_fire;
  logic gpio_last;
  assign fall = sclk_prev_q & ~s_sclk & ~s_cs_n & (state_q != ST_IDLE);
  assign shift_w = {shift_q[14:0], s_din};
  assign cmd_done = fall & (state_q == ST_CMD) & (cnt_q == `DWG_CMD_LAST);
  assign cmd_byte = shift_w[7:0];
  assign to_dac = cmd_byte[`DWG_NIB_HI] == `DWG_DAC_SEL_NIB;
  assign to_gpio = cmd_byte == `DWG_GPIO_READ;
  assign word_fire = fall & (state_q == ST_DAC) & (cnt_q == `DWG_WORD_LAST);
  assign gpio_last = fall & (state_q == ST_GPIO) & (cnt_q == `DWG_GPIO_LAST);

  // word field split, msb first, sub-bits dropped
  logic [3:0] ctrl;
  dwg_code_t data;
  logic [3:0] sel;
  assign ctrl = shift_w[`DWG_CTRL_FLD];
  assign data = shift_w[`DWG_DATA_FLD];
  assign sel = shift_w[`DWG_SEL_FLD];

  // operation decode
  logic op_clear;
  logic op_preset;
  logic op_load;
  logic op_wt;
  logic op_in_all;
  logic op_xfer;
  logic [1:0] ld_ch;
  assign op_clear = word_fire & (ctrl == `DWG_OP_CLRSET) & ~shift_w[`DWG_TOP_DATA];
  assign op_preset = word_fire & (ctrl == `DWG_OP_CLRSET) & shift_w[`DWG_TOP_DATA];
  assign op_load = word_fire & (ctrl >= `DWG_OP_LOAD0) & (ctrl <= `DWG_OP_LOAD3);
  assign op_wt = word_fire & ((ctrl == `DWG_OP_WT_A) | (ctrl == `DWG_OP_WT_B));
  assign op_in_all = word_fire & (ctrl == `DWG_OP_IN_ALL);
  assign op_xfer = word_fire & (ctrl == `DWG_OP_XFER);
  assign ld_ch = load_chan(ctrl);

  // next state and bit count
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (s_cs_n) begin
      state_d = ST_IDLE;
      cnt_d = `DWG_CNT_ZERO;
    end else if (state_q == ST_IDLE) begin
      state_d = ST_CMD;
      cnt_d = `DWG_CNT_ZERO;
    end else if (fall) begin
      cnt_d = cnt_q + `DWG_CNT_ONE;
      case (state_q)
        ST_CMD: begin
          if (cnt_q == `DWG_CMD_LAST) begin
            cnt_d = `DWG_CNT_ZERO;
            if (to_dac) begin
              state_d = ST_DAC;
            end else if (to_gpio) begin
              state_d = ST_GPIO;
            end else begin
              state_d = ST_SKIP;
            end
          end
        end
        ST_DAC: begin
          if (word_fire) begin
            state_d = ST_CMD;
            cnt_d = `DWG_CNT_ZERO;
          end
        end
        ST_GPIO: begin
          if (gpio_last) begin
            state_d = ST_CMD;
            cnt_d = `DWG_CNT_ZERO;
          end
        end
        default: begin
          cnt_d = `DWG_CNT_ZERO;
        end
      endcase
    end
  end

  // dout shifter: zeros then the four pin states, din ignored
  always_comb begin
    dout_sh_d = dout_sh_q;
    if (s_cs_n) begin
      dout_sh_d = `DWG_BYTE_ZERO;
    end else if (cmd_done & to_gpio) begin
      dout_sh_d = {`DWG_NIB_ZERO, s_gpio};
    end else if (fall & (state_q == ST_GPIO)) begin
      dout_sh_d = {dout_sh_q[6:0], 1'b0};
    end
  end

  // serial state registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      state_q <= ST_IDLE;
      cnt_q <= `DWG_CNT_ZERO;
      sclk_prev_q <= 1'b0;
      shift_q <= `DWG_WORD_ZERO;
      dout_sh_q <= `DWG_BYTE_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sclk_prev_q <= s_sclk;
      shift_q <= fall ? shift_w : shift_q;
      dout_sh_q <= dout_sh_d;
    end
  end

  // per-channel input and dac registers
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic ld_in;
    logic ld_dac;
    assign ld_in = (op_load & (ld_ch == i)) | op_wt | op_in_all;
    assign ld_dac = op_wt;
    always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
        in_q[i] <= `DWG_CODE_ZERO;
        dac_q[i] <= `DWG_CODE_ZERO;
      end else if (op_clear) begin
        in_q[i] <= `DWG_CODE_ZERO;
        dac_q[i] <= `DWG_CODE_ZERO;
      end else if (op_preset) begin
        in_q[i] <= `DWG_CODE_FULL;
        dac_q[i] <= `DWG_CODE_FULL;
      end else begin
        if (ld_in) begin
          in_q[i] <= data;
        end
        if (ld_dac) begin
          dac_q[i] <= data;
        end else if (op_xfer & sel[i]) begin
          dac_q[i] <= in_q[i];
        end
      end
    end
  end

  // outputs straight from the registers
  assign O_DOUT = dout_sh_q[7];
  assign O_DAC0_CODE = dac_q[0];
  assign O_DAC1_CODE = dac_q[1];
  assign O_DAC2_CODE = dac_q[2];
  assign O_DAC3_CODE = dac_q[3];
  assign O_IN0_CODE = in_q[0];
  assign O_IN1_CODE = in_q[1];
  assign O_IN2_CODE = in_q[2];
  assign O_IN3_CODE = in_q[3];

  // flat views for checking
  logic [39:0] dac_flat;
  logic [39:0] in_flat;
  logic op_nop;
  assign dac_flat = {dac_q[3], dac_q[2], dac_q[1], dac_q[0]};
  assign in_flat = {in_q[3], in_q[2], in_q[1], in_q[0]};
  assign op_nop = word_fire & ~(ctrl == `DWG_OP_CLRSET) & ~((ctrl >= `DWG_OP_LOAD0) & (ctrl <= `DWG_OP_LOAD3))
                  & ~(ctrl >= `DWG_OP_WT_A) | (word_fire & (ctrl == `DWG_OP_NOP_B));

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence seq_gpio_cmd;
    cmd_done & to_gpio;
  endsequence
  sequence seq_word(logic [3:0] c);
    word_fire & (ctrl == c);
  endsequence

  AST_GPIO_BYTE: assert property (seq_gpio_cmd |=> (dout_sh_q == {4'h0, $past(s_gpio)}) ##1 (O_DOUT == 1'b0))
    else $error("gpio read byte not loaded");
  AST_CLEAR: assert property (op_clear |=> (dac_flat == 40'h0) && (in_flat == 40'h0))
    else $error("clear did not zero registers");
  AST_PRESET: assert property (op_preset |=> (dac_flat == {40{1'b1}}) && (in_flat == {40{1'b1}}))
    else $error("preset did not fill registers");
  AST_LOAD_ONE: assert property (op_load |=> $stable(dac_flat) && (in_q[$past(ld_ch)] == $past(data)))
    else $error("single load wrong");
  AST_WRITE_THRU: assert property (op_wt |=> (dac_flat == {4{$past(data)}}) && (in_flat == {4{$past(data)}}))
    else $error("write-through wrong");
  AST_IN_ALL: assert property (seq_word(`DWG_OP_IN_ALL) |=> $stable(dac_flat) && (in_flat == {4{$past(data)}}))
    else $error("input-all load wrong");
  AST_XFER: assert property (op_xfer && sel[2] |=> dac_q[2] == $past(in_q[2]))
    else $error("transfer of channel two missed");
  AST_XFER_KEEP: assert property (op_xfer && !sel[1] |=> $stable(dac_q[1]))
    else $error("unselected channel changed");
  AST_NOP: assert property (op_nop |=> $stable(dac_flat) && $stable(in_flat))
    else $error("no-op changed a register");
  AST_DAC_SELECT: assert property (cmd_done && to_dac && !s_cs_n |=> state_q == ST_DAC)
    else $error("dac select byte not honoured");
  AST_SHIFT: assert property (fall |=> shift_q[0] == $past(s_din))
    else $error("din not sampled on falling edge");
  AST_DISCARD: assert property ((state_q == ST_DAC) && s_cs_n |=> (state_q == ST_IDLE) ##1 $stable(dac_flat))
    else $error("partial word not discarded");
endmodule
`default_nettype wire
